//--- common/irq_ctl_params.svh
// Constants for the CPU interrupt control block
// What this block does
// - Any reset clears all interrupt enables
// - Redirect needs global and source enables; peripherals also group
// - Flags set regardless of any enable
// - Entry flushes, clears global, pushes, saves, vectors
// - Global clear holds off; pending serviced later
// - Return pops PC, restores context, sets global
// - Synchronous latency three or four cycles
// - Asynchronous latency three to five cycles
// - Only clockless sources wake; enables preset
// - Wake vectors if global set, else resumes
// - Instruction after sleep runs before vectoring
// - Pin gives asynchronous edge interrupt, own enable
// - Edge select high rising, low falling
// - Valid edge sets pin flag, may redirect
// - Pin flag may set from Q4 to Q1
// - Entry shadows W, status, bank, FSRs, PC latch
`ifndef IRQ_CTL_PARAMS_SVH
`define IRQ_CTL_PARAMS_SVH
`define IRQ_VECTOR      15'h0004
`define IRQ_PC_RESET    15'h0000
`define IRQ_STATUS_KEEP 5'h07
`endif

//--- common/irq_ctl_pkg.sv
// Types for the CPU interrupt control block
package irq_ctl_pkg;
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_FLUSH = 2'b01,
    ST_VEC   = 2'b10,
    ST_WAKE  = 2'b11
  } irq_state_e;
endpackage : irq_ctl_pkg

//--- core/cpu_interrupt_control.sv
// CPU interrupt control: flags, gating, entry, return and context shadows
`timescale 1ns/1ns
`default_nettype none
`include "irq_ctl_params.svh"
module cpu_interrupt_control #(
  parameter int NPERIPH = 8
) (
  input  wire logic               REF_CLK,
  input  wire logic               RSTN,
  input  wire logic               EXT_PIN_IN,
  input  wire logic               Q4_PHASE,
  input  wire logic               INSN_END,
  input  wire logic [14:0]        PC_IN,
  input  wire logic               GLOBAL_EN_SET,
  input  wire logic               GLOBAL_EN_CLR,
  input  wire logic               GROUP_EN_WR,
  input  wire logic               GROUP_EN_VAL,
  input  wire logic               EXT_EN_WR,
  input  wire logic               EXT_EN_VAL,
  input  wire logic               EDGE_SEL_WR,
  input  wire logic               EDGE_SEL_VAL,
  input  wire logic               EXT_FLAG_CLR,
  input  wire logic [NPERIPH-1:0] PERIPH_EVENT,
  input  wire logic [NPERIPH-1:0] PERIPH_FLAG_CLR,
  input  wire logic               PERIPH_EN_WR,
  input  wire logic [NPERIPH-1:0] PERIPH_EN_VAL,
  input  wire logic               RETURN_OP,
  input  wire logic               SLEEPING,
  input  wire logic               WAKE_CLOCKLESS,
  input  wire logic [7:0]         W_IN,
  input  wire logic [4:0]         STATUS_IN,
  input  wire logic [4:0]         BSR_IN,
  input  wire logic [15:0]        FSR0_IN,
  input  wire logic [15:0]        FSR1_IN,
  input  wire logic [6:0]         PCLATH_IN,
  output logic                    GLOBAL_IRQ_ENABLE,
  output logic                    PERIPH_GROUP_IRQ_ENABLE,
  output logic                    EXT_PIN_IRQ_ENABLE,
  output logic                    EXT_PIN_EDGE_SELECT,
  output logic                    EXT_PIN_IRQ_FLAG,
  output logic [NPERIPH-1:0]      PERIPH_FLAG_REGS,
  output logic [NPERIPH-1:0]      PERIPH_ENABLE_REGS,
  output logic                    FLUSH,
  output logic                    PUSH,
  output logic [14:0]             PUSH_ADDR,
  output logic                    LOAD_PC,
  output logic [14:0]             NEW_PC,
  output logic                    RESTORE,
  output logic                    WAKE,
  output logic [7:0]              W_SHADOW,
  output logic [4:0]              STATUS_SHADOW,
  output logic [4:0]              BSR_SHADOW,
  output logic [15:0]             FSR0_SHADOW,
  output logic [15:0]             FSR1_SHADOW,
  output logic [6:0]              PCLATH_SHADOW
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and edge detect
  logic pin_s1_q, pin_s2_q, pin_s3_q;
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= EXT_PIN_IN;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end
  logic pin_edge;
  always_comb begin
    pin_edge = EXT_PIN_EDGE_SELECT ? (pin_s2_q & ~pin_s3_q)
                                   : (~pin_s2_q & pin_s3_q);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enables and flags
  logic glob_q, glob_d, grp_q, grp_d, pin_en_q, pin_en_d, edg_q, edg_d;
  logic pin_flag_q, pin_flag_d, pin_hold_q, pin_hold_d, pin_set;
  logic [NPERIPH-1:0] pif_q, pif_d, pie_q, pie_d;
  logic               entry, ret_go;
  always_comb begin
    glob_d = glob_q;
    if (GLOBAL_EN_CLR) glob_d = 1'b0;
    if (GLOBAL_EN_SET) glob_d = 1'b1;
    if (entry) glob_d = 1'b0;
    if (ret_go) glob_d = 1'b1;
    grp_d    = GROUP_EN_WR ? GROUP_EN_VAL : grp_q;
    pin_en_d = EXT_EN_WR ? EXT_EN_VAL : pin_en_q;
    edg_d    = EDGE_SEL_WR ? EDGE_SEL_VAL : edg_q;
    pie_d    = PERIPH_EN_WR ? PERIPH_EN_VAL : pie_q;
    // Edge held until the Q4..Q1 window; set wins over clear
    pin_set    = (pin_edge | pin_hold_q) & Q4_PHASE;
    pin_hold_d = (pin_edge | pin_hold_q) & ~Q4_PHASE;
    pin_flag_d = pin_set | (pin_flag_q & ~EXT_FLAG_CLR);
  end
  // Peripheral flags, set over clear
  for (genvar i = 0; i < NPERIPH; i++) begin : g_pf
    assign pif_d[i] = PERIPH_EVENT[i] | (pif_q[i] & ~PERIPH_FLAG_CLR[i]);
  end
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      glob_q     <= 1'b0;
      grp_q      <= 1'b0;
      pin_en_q   <= 1'b0;
      edg_q      <= 1'b1;
      pin_flag_q <= 1'b0;
      pin_hold_q <= 1'b0;
      pie_q      <= '0;
      pif_q      <= '0;
    end else begin
      glob_q     <= glob_d;
      grp_q      <= grp_d;
      pin_en_q   <= pin_en_d;
      edg_q      <= edg_d;
      pin_flag_q <= pin_flag_d;
      pin_hold_q <= pin_hold_d;
      pie_q      <= pie_d;
      pif_q      <= pif_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request gating and entry sequence
  logic pend;
  assign pend = (pin_flag_q & pin_en_q) | (grp_q & |(pif_q & pie_q));
  irq_ctl_pkg::irq_state_e st_q, st_d;
  logic [14:0] ret_q, ret_d;
  always_comb begin
    st_d   = st_q;
    ret_d  = ret_q;
    entry  = 1'b0;
    WAKE   = 1'b0;
    case (st_q)
      irq_ctl_pkg::ST_RUN: begin
        if (SLEEPING) begin
          if (pend & WAKE_CLOCKLESS) begin
            WAKE = 1'b1;
            st_d = glob_q ? irq_ctl_pkg::ST_WAKE : irq_ctl_pkg::ST_RUN;
          end
        end else if (glob_q & pend & INSN_END) begin
          entry = 1'b1;
          ret_d = PC_IN;
          st_d  = irq_ctl_pkg::ST_FLUSH;
        end
      end
      irq_ctl_pkg::ST_WAKE: begin
        // Instruction ends count only once the core is awake
        if (INSN_END & ~SLEEPING) begin
          entry = glob_q & pend;
          if (glob_q & pend) ret_d = PC_IN;
          st_d  = (glob_q & pend) ? irq_ctl_pkg::ST_FLUSH : irq_ctl_pkg::ST_RUN;
        end
      end
      irq_ctl_pkg::ST_FLUSH: st_d = irq_ctl_pkg::ST_VEC;
      irq_ctl_pkg::ST_VEC:   st_d = irq_ctl_pkg::ST_RUN;
      default:               st_d = irq_ctl_pkg::ST_RUN;
    endcase
  end
  assign ret_go = RETURN_OP & (st_q == irq_ctl_pkg::ST_RUN) & ~SLEEPING;

  ////////////////////////////////////////////////////////////////////////////
  // Context shadows and redirect outputs
  logic [7:0]  w_q, w_d;
  logic [4:0]  s_q, s_d, b_q, b_d;
  logic [15:0] f0_q, f0_d, f1_q, f1_d;
  logic [6:0]  pl_q, pl_d;
  logic        fl_q, fl_d, ps_q, ps_d, ld_q, ld_d, rs_q, rs_d;
  logic [14:0] np_q, np_d;
  always_comb begin
    w_d = w_q; s_d = s_q; b_d = b_q; f0_d = f0_q; f1_d = f1_q; pl_d = pl_q;
    if (entry) begin
      w_d  = W_IN;
      s_d  = STATUS_IN & `IRQ_STATUS_KEEP;
      b_d  = BSR_IN;
      f0_d = FSR0_IN;
      f1_d = FSR1_IN;
      pl_d = PCLATH_IN;
    end
    fl_d = entry;
    ps_d = entry;
    ld_d = entry | ret_go;
    np_d = entry ? `IRQ_VECTOR : ret_q;
    rs_d = ret_go;
  end
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_q <= irq_ctl_pkg::ST_RUN;
      ret_q <= `IRQ_PC_RESET;
      w_q <= '0; s_q <= '0; b_q <= '0; f0_q <= '0; f1_q <= '0; pl_q <= '0;
      fl_q <= 1'b0; ps_q <= 1'b0; ld_q <= 1'b0; rs_q <= 1'b0;
      np_q <= `IRQ_PC_RESET;
    end else begin
      st_q <= st_d;
      ret_q <= ret_d;
      w_q <= w_d; s_q <= s_d; b_q <= b_d; f0_q <= f0_d; f1_q <= f1_d; pl_q <= pl_d;
      fl_q <= fl_d; ps_q <= ps_d; ld_q <= ld_d; rs_q <= rs_d;
      np_q <= np_d;
    end
  end
  assign GLOBAL_IRQ_ENABLE       = glob_q;
  assign PERIPH_GROUP_IRQ_ENABLE = grp_q;
  assign EXT_PIN_IRQ_ENABLE      = pin_en_q;
  assign EXT_PIN_EDGE_SELECT     = edg_q;
  assign EXT_PIN_IRQ_FLAG        = pin_flag_q;
  assign PERIPH_FLAG_REGS        = pif_q;
  assign PERIPH_ENABLE_REGS      = pie_q;
  assign FLUSH = fl_q;
  assign PUSH = ps_q;
  assign PUSH_ADDR = ret_q;
  assign LOAD_PC = ld_q;
  assign NEW_PC = np_q;
  assign RESTORE = rs_q;
  assign W_SHADOW = w_q;
  assign STATUS_SHADOW = s_q;
  assign BSR_SHADOW = b_q;
  assign FSR0_SHADOW = f0_q;
  assign FSR1_SHADOW = f1_q;
  assign PCLATH_SHADOW = pl_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  reset_clear_a: assert property (@(posedge REF_CLK)
    $rose(RSTN) |-> !glob_q && !pin_en_q)
    else $error("enable set after reset");
  gated_entry_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    entry |-> glob_q && pend)
    else $error("entry without enables");
  flag_set_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    PERIPH_EVENT[0] |=> pif_q[0])
    else $error("flag not set");
  entry_seq_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    entry |=> FLUSH && PUSH && LOAD_PC && NEW_PC == `IRQ_VECTOR && !glob_q)
    else $error("entry sequence wrong");
  hold_off_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    !glob_q |=> !FLUSH || $past(entry))
    else $error("redirect while disabled");
  return_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    ret_go && !entry |=> RESTORE && glob_q && LOAD_PC && NEW_PC == PUSH_ADDR)
    else $error("return incomplete");
  pin_flag_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    pin_edge && Q4_PHASE |=> pin_flag_q)
    else $error("pin flag missed");
  status_mask_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    entry |=> (STATUS_SHADOW & ~`IRQ_STATUS_KEEP) == 5'h00)
    else $error("status shadow bits wrong");
  vec_cover: cover property (@(posedge REF_CLK) disable iff (!RSTN) entry ##3 ret_go);
  wake_cover: cover property (@(posedge REF_CLK) disable iff (!RSTN) WAKE && glob_q);
  pin_cover: cover property (@(posedge REF_CLK) disable iff (!RSTN) pin_edge && !edg_q);
endmodule : cpu_interrupt_control
`default_nettype wire

//--- tb/core_model.sv
// Core pipeline stand-in: instruction ends, phase window, program counter
`timescale 1ns/1ns
`default_nettype none
module core_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        load_pc,
  input  wire logic [14:0] new_pc,
  output logic             insn_end,
  output logic             q4_phase,
  output logic [14:0]      pc
);
  logic [1:0] ph_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ph_q <= 2'h0;
      pc <= 15'h0000;
    end else begin
      ph_q <= ph_q + 2'h1;
      if (load_pc) begin
        pc <= new_pc;
      end else if (insn_end) begin
        pc <= pc + 15'h0001;
      end
    end
  end
  // Four phases per instruction cycle
  assign insn_end = (ph_q == 2'h3);
  assign q4_phase = (ph_q == 2'h3) || (ph_q == 2'h0);
endmodule : core_model
`default_nettype wire

//--- tb/tb_cpu_interrupt_control.sv
// Self-checking bench for the CPU interrupt control block
`timescale 1ns/1ns
`default_nettype none
module tb_cpu_interrupt_control;
  logic REF_CLK, RSTN, EXT_PIN_IN, Q4_PHASE, INSN_END, GLOBAL_EN_SET, GLOBAL_EN_CLR;
  logic GROUP_EN_WR, GROUP_EN_VAL;
  logic EXT_EN_WR, EXT_EN_VAL, EDGE_SEL_WR, EDGE_SEL_VAL, EXT_FLAG_CLR, PERIPH_EN_WR;
  logic RETURN_OP, SLEEPING, WAKE_CLOCKLESS, GLOBAL_IRQ_ENABLE, PERIPH_GROUP_IRQ_ENABLE;
  logic EXT_PIN_IRQ_ENABLE, EXT_PIN_EDGE_SELECT, EXT_PIN_IRQ_FLAG, FLUSH, PUSH, LOAD_PC;
  logic RESTORE, WAKE;
  logic [7:0]  PERIPH_EVENT, PERIPH_FLAG_CLR, PERIPH_EN_VAL, PERIPH_FLAG_REGS;
  logic [7:0]  PERIPH_ENABLE_REGS, W_IN, W_SHADOW;
  logic [4:0]  STATUS_IN, BSR_IN, STATUS_SHADOW, BSR_SHADOW;
  logic [15:0] FSR0_IN, FSR1_IN, FSR0_SHADOW, FSR1_SHADOW;
  logic [6:0]  PCLATH_IN, PCLATH_SHADOW;
  logic [14:0] PC_IN, PUSH_ADDR, NEW_PC;
  int          error_cnt, n_compared;
  bit          hit;
  // Rows: global, group, source enable, entry expected
  logic [3:0]  rows [4] = '{4'b0110, 4'b1010, 4'b1100, 4'b1111};
  // Rows: edge select, pin level, flag expected
  logic [2:0]  pins [4] = '{3'b111, 3'b100, 3'b010, 3'b001};
  cpu_interrupt_control #(.NPERIPH(8)) i_cpu_interrupt_control (.*);
  core_model i_core_model (.clk(REF_CLK), .rstn(RSTN), .load_pc(LOAD_PC), .new_pc(NEW_PC),
    .insn_end(INSN_END), .q4_phase(Q4_PHASE), .pc(PC_IN));
  initial begin
    REF_CLK = 1'b0;
    forever #50 REF_CLK = ~REF_CLK;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_vec
  task automatic chk_bit(input logic got, input logic exp);
    chk_vec({15'h0000, got}, {15'h0000, exp});
  endtask : chk_bit
  function automatic logic sig(input int s);
    case (s)
      0: return FLUSH;
      1: return WAKE;
      2: return EXT_PIN_IRQ_FLAG;
      default: return RESTORE;
    endcase
  endfunction : sig
  task automatic wait_sig(input int s, input int n, input logic must, output bit h);
    h = 1'b0;
    for (int k = 0; k < n && !h; k++) begin
      @(negedge REF_CLK);
      h = (sig(s) === 1'b1);
    end
    if (must && !h) begin
      error_cnt++;
      $display("wrong value at %0t: wait %0d ran out", $time, s);
      give_verdict();
    end
  endtask : wait_sig
  task automatic set_en(input logic g, input logic p, input logic e);
    @(posedge REF_CLK);
    {GROUP_EN_WR, PERIPH_EN_WR, EXT_EN_WR, GLOBAL_EN_SET, GLOBAL_EN_CLR} <= {3'b111, g, !g};
    {GROUP_EN_VAL, EXT_EN_VAL, PERIPH_EN_VAL} <= {p, e, 7'h00, e};
    @(posedge REF_CLK);
    {GROUP_EN_WR, PERIPH_EN_WR, EXT_EN_WR, GLOBAL_EN_SET, GLOBAL_EN_CLR} <= 5'h00;
  endtask : set_en
  task automatic event0;
    @(posedge REF_CLK);
    PERIPH_EVENT <= 8'h01;
    @(posedge REF_CLK);
    PERIPH_EVENT <= 8'h00;
  endtask : event0
  task automatic rst_chk;
    @(negedge REF_CLK);
    chk_bit(GLOBAL_IRQ_ENABLE, 1'b0);
    chk_bit(PERIPH_GROUP_IRQ_ENABLE, 1'b0);
    chk_bit(EXT_PIN_IRQ_ENABLE, 1'b0);
    chk_vec(16'(PERIPH_ENABLE_REGS), 16'h0000);
    chk_bit(EXT_PIN_EDGE_SELECT, 1'b1);
  endtask : rst_chk
  // Entry seen, context checked, flags cleared, then return
  task automatic serve;
    logic [14:0] ret_addr;
    wait_sig(0, 12, 1'b1, hit);
    ret_addr = PC_IN - 15'h0001;
    chk_bit(PUSH, 1'b1);
    chk_bit(LOAD_PC, 1'b1);
    chk_vec(16'(NEW_PC), 16'h0004);
    chk_vec(16'(PUSH_ADDR), 16'(ret_addr));
    chk_bit(GLOBAL_IRQ_ENABLE, 1'b0);
    chk_vec(16'(W_SHADOW), 16'(W_IN));
    chk_vec(16'(STATUS_SHADOW), 16'h0007);
    chk_vec(FSR1_SHADOW, FSR1_IN);
    chk_vec(FSR0_SHADOW, 16'h1234);
    chk_vec(16'(BSR_SHADOW), 16'h000a);
    chk_vec(16'(PCLATH_SHADOW), 16'h0033);
    @(posedge REF_CLK);
    {EXT_FLAG_CLR, PERIPH_FLAG_CLR} <= 9'h1ff;
    @(posedge REF_CLK);
    {EXT_FLAG_CLR, PERIPH_FLAG_CLR, RETURN_OP} <= 10'h001;
    @(posedge REF_CLK);
    RETURN_OP <= 1'b0;
    wait_sig(3, 4, 1'b1, hit);
    chk_bit(GLOBAL_IRQ_ENABLE, 1'b1);
    chk_vec(16'(NEW_PC), 16'(ret_addr));
  endtask : serve
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {RSTN, EXT_PIN_IN, GLOBAL_EN_SET, GLOBAL_EN_CLR, GROUP_EN_WR, GROUP_EN_VAL, EXT_EN_WR,
      EXT_EN_VAL,
      EDGE_SEL_WR, EDGE_SEL_VAL, EXT_FLAG_CLR, PERIPH_EN_WR, RETURN_OP, SLEEPING,
      WAKE_CLOCKLESS, PERIPH_EVENT, PERIPH_FLAG_CLR, PERIPH_EN_VAL} = '0;
    {W_IN, STATUS_IN, BSR_IN, PCLATH_IN} = {8'h00, 5'h1f, 5'h0a, 7'h33};
    {FSR0_IN, FSR1_IN} = {16'h1234, 16'h5678};
    error_cnt = 0;
    n_compared = 0;
    rst_chk();
    repeat (4) @(posedge REF_CLK);
    RSTN <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge REF_CLK);
      {W_IN, FSR1_IN} <= {8'h11 + 8'(i), 16'h5678 + 16'(i)};
      set_en(rows[i][3], rows[i][2], rows[i][1]);
      event0();
      @(negedge REF_CLK);
      chk_bit(PERIPH_FLAG_REGS[0], 1'b1);
      if (rows[i][0]) serve();
      else wait_sig(0, 12, 1'b0, hit);
      chk_bit(hit, rows[i][0]);
      @(posedge REF_CLK);
      PERIPH_FLAG_CLR <= 8'hff;
      set_en(1'b0, 1'b0, 1'b0);
      PERIPH_FLAG_CLR <= 8'h00;
    end
    set_en(1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      @(posedge REF_CLK);
      {EXT_FLAG_CLR, EDGE_SEL_WR, EDGE_SEL_VAL, EXT_PIN_IN} <= {2'b11, pins[i][2], pins[i][1]};
      @(posedge REF_CLK);
      {EXT_FLAG_CLR, EDGE_SEL_WR} <= 2'b00;
      wait_sig(2, 8, 1'b0, hit);
      chk_bit(hit, pins[i][0]);
    end
    set_en(1'b1, 1'b0, 1'b1);
    serve();
    @(posedge REF_CLK);
    {SLEEPING, WAKE_CLOCKLESS} <= 2'b11;
    set_en(1'b1, 1'b1, 1'b1);
    event0();
    wait_sig(1, 6, 1'b1, hit);
    wait_sig(0, 8, 1'b0, hit);
    chk_bit(hit, 1'b0);
    @(posedge REF_CLK);
    SLEEPING <= 1'b0;
    serve();
    @(posedge REF_CLK);
    RSTN <= 1'b0;
    rst_chk();
    give_verdict();
  end
endmodule : tb_cpu_interrupt_control
`default_nettype wire
